// file: asf_pkg.sv
// Operation
// - fault clear wipes axis errors, moves fault-halt to idle-hold, done at idle-hold
// - fault clear leaves other command outputs alone and is no hardware reset
// - uncleared or new error keeps fault-halt, code reported, done stays low
// - fault clear outside fault-halt does nothing but raises done and warning
// - fault clear starts only on a rising edge of its trigger
// - fault clear outputs start busy=1, others 0; busy high until complete
// - every move's speed, accel, decel and jerk are multiplied by current factors
// - factors tracked while enabled, last factors kept after disable
// - applying factors never changes the axis state machine
// - factors ignored on a follower axis in synchronized motion
// - enable high gives enabled and busy; warning on a warning condition
// - scaling error drops enabled, busy and warning
// - enable falling with valid factors clears every scaling output
// - valid-to-invalid factors while enabled: error, code, hold last valid factors
// - scaled speed, accel and jerk never fall below their fixed floors
// - jerk factor applies only to jerk in units per second cubed
// - speed factor legal only as 0.0 or 0.01 to 1.20, never negative
// - speed factor 0.0 is a feed hold without entering idle-hold
// - new speed factor acts at once on motion in progress and persists
// - speed factor above 1.0 pushing speed past the system limit is an error
// - speed factor defaults to 1
// - accel factor scales accel and decel; accel and jerk factors 0.01 to 1.20, default 1
package asf_pkg;
  localparam int ASF_FW = 8;
  localparam int ASF_CW = 24;
  localparam int ASF_CLK_MHZ = 50;
  // factors are in hundredths, signed so that negative entries can be refused
  localparam logic [7:0] ASF_SCALE_ONE = 8'h64;
  localparam logic [7:0] ASF_SCALE_MIN = 8'h01;
  localparam logic [7:0] ASF_SCALE_MAX = 8'h78;
  localparam logic [7:0] ASF_SCALE_DIV = 8'h64;
  // move values are in units of their own floor
  localparam logic [23:0] ASF_SPEED_FLOOR = 24'h000001;
  localparam logic [23:0] ASF_ACCEL_FLOOR = 24'h000001;
  localparam logic [23:0] ASF_JERK_FLOOR = 24'h000001;
  localparam logic [15:0] ASF_FC_NONE = 16'h0000;
  localparam logic [15:0] ASF_FC_NOT_HALTED = 16'h0001;
  localparam logic [15:0] ASF_FC_CLR_TIMEOUT = 16'h0002;
  localparam logic [15:0] ASF_FC_BAD_SCALE = 16'h0010;
  localparam logic [15:0] ASF_FC_OVER_SPEED = 16'h0011;
  localparam logic [15:0] ASF_FC_AT_FLOOR = 16'h0012;
  localparam logic [15:0] ASF_CLR_SETTLE_CYC = 16'h0002;
  localparam int ASF_CLR_TIMEOUT_US = 200;
  localparam int ASF_CLR_TIMEOUT_CYC = ASF_CLR_TIMEOUT_US * ASF_CLK_MHZ;

  typedef enum logic [2:0] {
    CLR_INIT, CLR_IDLE, CLR_WAIT, CLR_DONE, CLR_WARN, CLR_FAIL
  } asf_clr_st_t;
  typedef enum logic [1:0] {OVR_OFF, OVR_ON, OVR_FAULT} asf_ovr_st_t;

  typedef struct packed {
    logic [7:0] speed;
    logic [7:0] accel;
    logic [7:0] jerk;
  } asf_scale_t;
  typedef struct packed {
    logic [23:0] vel;
    logic [23:0] acc;
    logic [23:0] dec;
    logic [23:0] jerk;
    logic jerk_pct;
  } asf_move_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic warning;
    logic error;
    logic [15:0] fault_code;
  } asf_clr_stat_t;
  typedef struct packed {
    logic enabled;
    logic busy;
    logic warning;
    logic error;
    logic [15:0] fault_code;
  } asf_ovr_stat_t;
  typedef struct packed {
    logic exec_s1;
    logic exec_s2;
    logic exec_p;
    logic en_s1;
    logic en_s2;
    asf_scale_t sc_s1;
    asf_scale_t sc_s2;
    asf_scale_t sc_s3;
    asf_clr_st_t clr;
    logic [15:0] cnt;
    logic err_clear;
    asf_clr_stat_t cst;
    asf_ovr_st_t ovr;
    asf_scale_t applied;
    asf_ovr_stat_t ost;
    asf_move_t mout;
  } asf_state_t;
endpackage

// file: asf_axis.sv
module asf_axis import asf_pkg::*; #(
  parameter int CLR_TIMEOUT_CYC = ASF_CLR_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fault-clear command
  input wire logic clr_execute,
  output asf_clr_stat_t clr_stat,
  // axis core
  input wire logic axis_fault_halt,
  input wire logic axis_idle_hold,
  input wire logic axis_err_active,
  input wire logic [15:0] axis_err_code,
  input wire logic axis_follower,
  output logic axis_err_clear,
  // scaling command
  input wire logic scale_enable,
  input asf_scale_t scale_in,
  output asf_ovr_stat_t ovr_stat,
  // moves
  input asf_move_t move_in,
  input wire logic [23:0] speed_limit,
  output asf_move_t move_out
);
  localparam logic [15:0] TMO = 16'(CLR_TIMEOUT_CYC - 1);

  asf_state_t q, d;
  logic exec_rise;
  logic ok_now;
  logic over_now;
  logic [23:0] vel_try;
  logic sc_steady;

  function automatic logic scale_ok(logic [7:0] f, logic zero_ok);
    scale_ok = !f[7] && ((zero_ok && f == 8'h00) ||
               (f >= ASF_SCALE_MIN && f <= ASF_SCALE_MAX));
  endfunction

  function automatic logic [23:0] scale_raw(logic [23:0] v, logic [7:0] f);
    logic [31:0] p;
    p = 32'(v) * 32'(f);
    scale_raw = 24'(p / 32'(ASF_SCALE_DIV));
  endfunction

  // clamp up to floor; a zero command or a zero factor stays zero so a hold stays a hold
  function automatic logic [23:0] scale_fl(logic [23:0] v, logic [7:0] f,
                                           logic [23:0] fl);
    logic [23:0] r;
    r = scale_raw(v, f);
    scale_fl = (v != 24'h0 && f != 8'h00 && r < fl) ? fl : r;
  endfunction

  function automatic logic below(logic [23:0] v, logic [7:0] f, logic [23:0] fl);
    below = v != 24'h0 && f != 8'h00 && scale_raw(v, f) < fl;
  endfunction

  assign exec_rise = q.exec_s2 && !q.exec_p;
  // a factor word sampled while its bits move is torn; act only on two equal samples
  assign sc_steady = q.sc_s2 == q.sc_s3;
  assign ok_now = scale_ok(q.sc_s2.speed, 1'b1) && scale_ok(q.sc_s2.accel, 1'b0) &&
                  scale_ok(q.sc_s2.jerk, 1'b0);
  assign vel_try = scale_raw(move_in.vel, q.sc_s2.speed);
  assign over_now = q.sc_s2.speed > ASF_SCALE_ONE && vel_try > speed_limit;

  always_comb begin
    d = q;
    // application pins pass two stages; a factor word counts only once two samples agree
    d.exec_s1 = clr_execute;
    d.exec_s2 = q.exec_s1;
    d.exec_p = q.exec_s2;
    d.en_s1 = scale_enable;
    d.en_s2 = q.en_s1;
    d.sc_s1 = scale_in;
    d.sc_s2 = q.sc_s1;
    d.sc_s3 = q.sc_s2;
    d.err_clear = 1'b0;

    // fault clear only pulses the axis error clear, never a module reset
    case (q.clr)
      CLR_INIT: begin
        if (!q.exec_s2) begin
          d.clr = CLR_IDLE;
          d.cst.busy = 1'b0;
        end
      end
      CLR_IDLE: begin
        if (exec_rise) begin
          if (axis_fault_halt) begin
            d.clr = CLR_WAIT;
            d.cnt = 16'h0;
            d.err_clear = 1'b1;
            d.cst.busy = 1'b1;
          end else begin
            d.clr = CLR_WARN;
            d.cst.done = 1'b1;
            d.cst.warning = 1'b1;
            d.cst.fault_code = ASF_FC_NOT_HALTED;
          end
        end
      end
      CLR_WAIT: begin
        d.cnt = q.cnt + 16'h1;
        if (axis_idle_hold && !axis_err_active) begin
          d.clr = CLR_DONE;
          d.cst.busy = 1'b0;
          d.cst.done = 1'b1;
        end else if (q.cnt >= ASF_CLR_SETTLE_CYC && axis_err_active) begin
          d.clr = CLR_FAIL;
          d.cst.busy = 1'b0;
          d.cst.error = 1'b1;
          d.cst.fault_code = axis_err_code;
        end else if (q.cnt >= TMO) begin
          d.clr = CLR_FAIL;
          d.cst.busy = 1'b0;
          d.cst.error = 1'b1;
          d.cst.fault_code = ASF_FC_CLR_TIMEOUT;
        end
      end
      default: begin
        // results stand until the trigger goes low, so a slow poller sees them
        if (!q.exec_s2) begin
          d.clr = CLR_IDLE;
          d.cst = '0;
        end
      end
    endcase

    // scaling never drives axis state; it only reshapes move values
    case (q.ovr)
      OVR_OFF: begin
        if (q.en_s2 && sc_steady) begin
          if (!ok_now || over_now) begin
            d.ovr = OVR_FAULT;
            d.ost = '0;
            d.ost.error = 1'b1;
            d.ost.fault_code = ok_now ? ASF_FC_OVER_SPEED : ASF_FC_BAD_SCALE;
          end else begin
            d.ovr = OVR_ON;
            d.applied = q.sc_s2;
            d.ost.enabled = 1'b1;
            d.ost.busy = 1'b1;
          end
        end
      end
      OVR_ON: begin
        if (!q.en_s2) begin
          d.ovr = OVR_OFF;
          d.ost = '0;
        end else if (!sc_steady) begin
          d.ovr = OVR_ON;
        end else if (!ok_now || over_now) begin
          // applied keeps the last valid set, as after a disable
          d.ovr = OVR_FAULT;
          d.ost = '0;
          d.ost.error = 1'b1;
          d.ost.fault_code = ok_now ? ASF_FC_OVER_SPEED : ASF_FC_BAD_SCALE;
        end else begin
          d.applied = q.sc_s2;
          d.ost.enabled = 1'b1;
          d.ost.busy = 1'b1;
          d.ost.warning = below(move_in.vel, q.sc_s2.speed, ASF_SPEED_FLOOR) ||
                          below(move_in.acc, q.sc_s2.accel, ASF_ACCEL_FLOOR) ||
                          below(move_in.dec, q.sc_s2.accel, ASF_ACCEL_FLOOR) ||
                          (!move_in.jerk_pct &&
                           below(move_in.jerk, q.sc_s2.jerk, ASF_JERK_FLOOR));
          d.ost.fault_code = d.ost.warning ? ASF_FC_AT_FLOOR : ASF_FC_NONE;
        end
      end
      default: begin
        if (!q.en_s2) begin
          d.ovr = OVR_OFF;
          d.ost = '0;
        end
      end
    endcase

    // follower axes take the master's profile, so factors are bypassed
    if (axis_follower) begin
      d.mout = move_in;
    end else begin
      d.mout.jerk_pct = move_in.jerk_pct;
      // speed factor zero gives a zero speed: a feed hold, axis stays in motion
      d.mout.vel = scale_fl(move_in.vel, q.applied.speed, ASF_SPEED_FLOOR);
      d.mout.acc = scale_fl(move_in.acc, q.applied.accel, ASF_ACCEL_FLOOR);
      d.mout.dec = scale_fl(move_in.dec, q.applied.accel, ASF_ACCEL_FLOOR);
      if (move_in.jerk_pct) begin
        d.mout.jerk = move_in.jerk;
      end else begin
        d.mout.jerk = scale_fl(move_in.jerk, q.applied.jerk, ASF_JERK_FLOOR);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.clr <= CLR_INIT;
      q.cst.busy <= 1'b1;
      q.ovr <= OVR_OFF;
      q.applied.speed <= ASF_SCALE_ONE;
      q.applied.accel <= ASF_SCALE_ONE;
      q.applied.jerk <= ASF_SCALE_ONE;
    end else begin
      q <= d;
    end
  end

  assign clr_stat = q.cst;
  assign ovr_stat = q.ost;
  assign axis_err_clear = q.err_clear;
  assign move_out = q.mout;

  sequence s_rise_halted;
    exec_rise && q.clr == CLR_IDLE && axis_fault_halt;
  endsequence
  sequence s_rise_other;
    exec_rise && q.clr == CLR_IDLE && !axis_fault_halt;
  endsequence
  sequence s_result_held;
    (q.cst.done || q.cst.error) && q.exec_s2;
  endsequence

  AST_CLR_START: assert property (@(posedge clock) disable iff (!rst_n)
    s_rise_halted |=> axis_err_clear && clr_stat.busy && !clr_stat.done)
    else $error("fault clear did not start");
  AST_CLR_WARN: assert property (@(posedge clock) disable iff (!rst_n)
    s_rise_other |=> clr_stat.done && clr_stat.warning && !axis_err_clear)
    else $error("fault clear outside fault-halt not flagged");
  AST_CLR_DONE_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(clr_stat.done) && !clr_stat.warning |-> $past(axis_idle_hold))
    else $error("done without idle-hold");
  AST_CLR_FAIL: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(clr_stat.error) |-> !clr_stat.done && !clr_stat.busy &&
      clr_stat.fault_code != ASF_FC_NONE)
    else $error("failed clear reported wrongly");
  AST_CLR_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    s_result_held |=> (clr_stat.done || clr_stat.error) && !clr_stat.busy)
    else $error("clear result not held");
  AST_OVR_ON: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_ON && q.en_s2 && ok_now && !over_now |=> ovr_stat.enabled &&
      ovr_stat.busy)
    else $error("enabled or busy missing");
  AST_OVR_ERR: assert property (@(posedge clock) disable iff (!rst_n)
    ovr_stat.error |-> !ovr_stat.enabled && !ovr_stat.busy && !ovr_stat.warning)
    else $error("outputs live during scaling error");
  AST_OVR_FALL: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_ON && !q.en_s2 |=> ovr_stat == '0)
    else $error("outputs not cleared on disable");
  AST_OVR_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_ON && q.en_s2 && sc_steady && !ok_now |=> ovr_stat.error &&
      $stable(q.applied) ##1 $stable(q.applied))
    else $error("last valid factors not held");
  AST_SCALE_FLOOR: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) && $past(move_in.acc) != 24'h0 |-> move_out.acc >= ASF_ACCEL_FLOOR)
    else $error("scaled accel below floor");

  sequence s_bad_entry;
    q.ovr != OVR_FAULT && q.en_s2 && sc_steady && !ok_now;
  endsequence
  sequence s_fast_entry;
    q.ovr != OVR_FAULT && q.en_s2 && sc_steady && ok_now && over_now;
  endsequence
  sequence s_track;
    q.ovr == OVR_ON && q.en_s2 && sc_steady && ok_now && !over_now;
  endsequence
  sequence s_wait_err;
    q.clr == CLR_WAIT && q.cnt >= ASF_CLR_SETTLE_CYC && axis_err_active;
  endsequence

  // fault clear checks
  AST_CLR_INIT_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
    q.clr == CLR_INIT |-> clr_stat.busy && !clr_stat.done && !clr_stat.error)
    else $error("fault clear not busy before first use");
  AST_CLR_WAIT_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
    q.clr == CLR_WAIT |-> clr_stat.busy && !clr_stat.done && !clr_stat.error)
    else $error("fault clear not busy while clearing");
  AST_CLR_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    axis_err_clear |=> !axis_err_clear)
    else $error("axis error clear longer than one cycle");
  AST_CLR_ONLY_RISE: assert property (@(posedge clock) disable iff (!rst_n)
    q.clr == CLR_IDLE && !exec_rise |=> !axis_err_clear && !clr_stat.busy &&
      !clr_stat.done)
    else $error("fault clear acted without a rising trigger");
  AST_CLR_WARN_CODE: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(clr_stat.warning) |-> clr_stat.done && clr_stat.fault_code == ASF_FC_NOT_HALTED)
    else $error("warning without done or code");
  AST_CLR_EXCL: assert property (@(posedge clock) disable iff (!rst_n)
    clr_stat.error |-> !clr_stat.done && !clr_stat.warning)
    else $error("failed clear also reports done");
  AST_CLR_ERR_CODE: assert property (@(posedge clock) disable iff (!rst_n)
    s_wait_err |=> clr_stat.error && clr_stat.fault_code == $past(axis_err_code))
    else $error("uncleared axis error not reported");
  AST_CLR_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
    q.clr == CLR_WAIT && q.cnt >= TMO |=> q.clr != CLR_WAIT)
    else $error("fault clear outlived its timeout");
  AST_CLR_DONE_FREE: assert property (@(posedge clock) disable iff (!rst_n)
    clr_stat.done |-> !clr_stat.busy)
    else $error("done while busy");
  AST_CLR_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
    (clr_stat.done || clr_stat.error) && !q.exec_s2 |=> clr_stat == '0)
    else $error("clear result not dropped after trigger low");
  AST_AXIS_UNTOUCHED: assert property (@(posedge clock) disable iff (!rst_n)
    !(q.clr == CLR_IDLE && exec_rise) |=> !axis_err_clear)
    else $error("axis error clear without a fault clear");

  // scaling checks
  AST_OVR_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_OFF && !q.en_s2 |=> ovr_stat == '0)
    else $error("idle scaling unit shows outputs");
  AST_OVR_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_OFF && !q.en_s2 |=> $stable(q.applied))
    else $error("factors changed while disabled");
  AST_OVR_TRACK: assert property (@(posedge clock) disable iff (!rst_n)
    s_track |=> q.applied == $past(q.sc_s2))
    else $error("factors not followed while enabled");
  AST_OVR_FAULT_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    q.ovr == OVR_FAULT |=> $stable(q.applied))
    else $error("factors changed during scaling error");
  AST_OVR_BAD: assert property (@(posedge clock) disable iff (!rst_n)
    s_bad_entry |=> ovr_stat.error && ovr_stat.fault_code == ASF_FC_BAD_SCALE)
    else $error("out of range factor accepted");
  AST_OVR_FAST: assert property (@(posedge clock) disable iff (!rst_n)
    s_fast_entry |=> ovr_stat.error && ovr_stat.fault_code == ASF_FC_OVER_SPEED)
    else $error("overspeed factor accepted");
  AST_OVR_WARN: assert property (@(posedge clock) disable iff (!rst_n)
    ovr_stat.warning |-> ovr_stat.enabled && ovr_stat.fault_code == ASF_FC_AT_FLOOR)
    else $error("warning without enabled or code");

  // move checks
  AST_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
    axis_follower |=> move_out == $past(move_in))
    else $error("follower move was scaled");
  AST_JERK_PCT: assert property (@(posedge clock) disable iff (!rst_n)
    move_in.jerk_pct |=> move_out.jerk_pct && move_out.jerk == $past(move_in.jerk))
    else $error("percent jerk was scaled");
  AST_FEED_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !axis_follower && q.applied.speed == 8'h00 |=> move_out.vel == 24'h000000)
    else $error("zero speed factor did not hold the feed");
  AST_ACC_DEC: assert property (@(posedge clock) disable iff (!rst_n)
    move_in.acc == move_in.dec |=> move_out.acc == move_out.dec)
    else $error("accel and decel scaled differently");
  AST_SPEED_FLOOR: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) && $past(move_in.vel) != 24'h0 && $past(q.applied.speed) != 8'h00 |->
      move_out.vel >= ASF_SPEED_FLOOR)
    else $error("scaled speed below floor");
  AST_JERK_FLOOR: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) && $past(move_in.jerk) != 24'h0 |-> move_out.jerk >= ASF_JERK_FLOOR)
    else $error("scaled jerk below floor");
endmodule

// file: asf_core_model.sv
module asf_core_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // scenario control from the bench
  input wire logic go_halt,
  input wire logic sticky,
  // axis core side
  input wire logic err_clear,
  output logic fault_halt,
  output logic idle_hold,
  output logic err_active,
  output logic [15:0] err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_q;
  // idle-hold comes a cycle after the clear, so done cannot ride on the pulse itself
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_halt <= 1'b0;
      idle_hold <= 1'b1;
      err_active <= 1'b0;
      err_code <= 16'h0000;
      pend_q <= 1'b0;
    end else if (go_halt) begin
      fault_halt <= 1'b1;
      idle_hold <= 1'b0;
      err_active <= 1'b1;
      err_code <= 16'h0abc;
    end else if (err_clear && !sticky) begin
      err_active <= 1'b0;
      err_code <= 16'h0000;
      pend_q <= 1'b1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      fault_halt <= 1'b0;
      idle_hold <= 1'b1;
    end
  end
endmodule

// file: tb_top.sv
module tb_top;
  import asf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    asf_scale_t sc;
    logic jpct;
    logic [95:0] exp_mv;
  } asf_row_t;
  logic clock = 1'b0;
  logic rst_n, clr_execute, axis_follower, scale_enable, go_halt, sticky;
  logic fh, ih, ea, ec;
  logic [15:0] code;
  logic [23:0] speed_limit;
  asf_scale_t scale_in;
  asf_scale_t bad [2];
  asf_move_t move_in, move_out;
  asf_clr_stat_t clr_stat;
  asf_ovr_stat_t ovr_stat;
  asf_row_t rows [4];
  int n_mismatch = 0;
  int num_checks = 0;
  always #10 clock = ~clock;
  asf_axis #(.CLR_TIMEOUT_CYC(16)) dut_u (.clock(clock), .rst_n(rst_n),
    .clr_execute(clr_execute), .clr_stat(clr_stat), .axis_fault_halt(fh),
    .axis_idle_hold(ih), .axis_err_active(ea), .axis_err_code(code),
    .axis_follower(axis_follower), .axis_err_clear(ec), .scale_enable(scale_enable),
    .scale_in(scale_in), .ovr_stat(ovr_stat), .move_in(move_in),
    .speed_limit(speed_limit), .move_out(move_out));
  asf_core_model core_u (.clock(clock), .rst_n(rst_n), .go_halt(go_halt),
    .sticky(sticky), .err_clear(ec), .fault_halt(fh), .idle_hold(ih),
    .err_active(ea), .err_code(code));
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // bounded wait: a lost answer ends the run instead of hanging it
  task clr_run;
    int i;
    clr_execute = 1'b1;
    for (i = 0; i < 40 && clr_stat.done !== 1'b1 && clr_stat.error !== 1'b1; i++) tick(1);
    if (i == 40) begin
      n_mismatch++;
      $display("BAD %0t clear never finished", $time);
      conclude();
    end
  endtask
  task clr_drop;
    clr_execute = 1'b0;
    tick(6);
    chk(clr_stat, 20'h00000);
  endtask
  task ovr_set(input asf_scale_t s, input logic en);
    scale_in = s;
    scale_enable = en;
    tick(6);
  endtask
  task halt_axis;
    go_halt = 1'b1;
    tick(1);
    go_halt = 1'b0;
    tick(2);
  endtask
  initial begin
    rst_n = 1'b0;
    clr_execute = 1'b0;
    axis_follower = 1'b0;
    scale_enable = 1'b0;
    go_halt = 1'b0;
    sticky = 1'b0;
    speed_limit = 24'h000800;
    scale_in = '{8'h64, 8'h64, 8'h64};
    move_in = '{24'h0003e8, 24'h000190, 24'h0000c8, 24'h000064, 1'b0};
    rows[0] = '{'{8'h64, 8'h64, 8'h64}, 1'b0, {24'h0003e8, 24'h000190, 24'h0000c8, 24'h000064}};
    rows[1] = '{'{8'h32, 8'h19, 8'h0a}, 1'b0, {24'h0001f4, 24'h000064, 24'h000032, 24'h00000a}};
    rows[2] = '{'{8'h78, 8'h78, 8'h78}, 1'b1, {24'h0004b0, 24'h0001e0, 24'h0000f0, 24'h000064}};
    rows[3] = '{'{8'h00, 8'h01, 8'h01}, 1'b0, {24'h000000, 24'h000004, 24'h000002, 24'h000001}};
    bad[0] = '{8'h9c, 8'h64, 8'h64};
    bad[1] = '{8'h32, 8'h00, 8'h64};
    tick(12);
    chk(clr_stat, {4'b1000, 16'h0000});
    chk({ovr_stat, move_out}, 117'h0);
    rst_n = 1'b1;
    tick(6);
    chk(move_out, move_in);
    foreach (rows[k]) begin
      move_in.jerk_pct = rows[k].jpct;
      ovr_set(rows[k].sc, 1'b1);
      chk(ovr_stat, {4'b1100, 16'h0000});
      chk({move_out.vel, move_out.acc, move_out.dec, move_out.jerk}, rows[k].exp_mv);
      ovr_set(rows[k].sc, 1'b0);
      chk(ovr_stat, 20'h00000);
      chk({move_out.vel, move_out.acc}, rows[k].exp_mv[95:48]);
    end
    chk(move_out.vel, 24'h000000);
    chk({fh, ih}, 2'b01);
    move_in.jerk_pct = 1'b0;
    foreach (bad[k]) begin
      ovr_set('{8'h32, 8'h64, 8'h64}, 1'b1);
      ovr_set(bad[k], 1'b1);
      chk(ovr_stat, {4'b0001, ASF_FC_BAD_SCALE});
      chk(move_out.vel, 24'h0001f4);
      ovr_set(bad[k], 1'b0);
    end
    speed_limit = 24'h000400;
    ovr_set('{8'h78, 8'h64, 8'h64}, 1'b1);
    chk(ovr_stat, {4'b0001, ASF_FC_OVER_SPEED});
    ovr_set('{8'h64, 8'h64, 8'h64}, 1'b0);
    speed_limit = 24'h000800;
    move_in.vel = 24'h000001;
    ovr_set('{8'h64, 8'h64, 8'h64}, 1'b1);
    ovr_set('{8'h32, 8'h64, 8'h64}, 1'b1);
    chk(ovr_stat, {4'b1110, ASF_FC_AT_FLOOR});
    chk(move_out.vel, 24'h000001);
    ovr_set('{8'h32, 8'h64, 8'h64}, 1'b0);
    move_in.vel = 24'h0003e8;
    axis_follower = 1'b1;
    ovr_set('{8'h32, 8'h32, 8'h32}, 1'b1);
    chk(move_out, move_in);
    ovr_set('{8'h32, 8'h32, 8'h32}, 1'b0);
    axis_follower = 1'b0;
    // scaling stays enabled through the clears to show they leave it alone
    ovr_set('{8'h64, 8'h64, 8'h64}, 1'b1);
    clr_run();
    chk(clr_stat, {4'b0110, ASF_FC_NOT_HALTED});
    clr_drop();
    halt_axis();
    clr_run();
    chk(clr_stat, {4'b0100, ASF_FC_NONE});
    chk({fh, ih}, 2'b01);
    chk(ovr_stat, {4'b1100, 16'h0000});
    clr_drop();
    sticky = 1'b1;
    halt_axis();
    clr_run();
    chk(clr_stat, {4'b0001, 16'h0abc});
    chk(fh, 1'b1);
    clr_drop();
    conclude();
  end
endmodule
